// ===== common/srp_pkg.sv
`default_nettype none
package srp_pkg;
  // Register addresses
  localparam logic [4:0] ADDR_WAVEFORM   = 5'h01;
  localparam logic [4:0] ADDR_ENERGY     = 5'h02;
  localparam logic [4:0] ADDR_ENERGY_CLR = 5'h03;
  localparam logic [4:0] ADDR_STATUS     = 5'h04;
  localparam logic [4:0] ADDR_STATUS_CLR = 5'h05;
  localparam logic [4:0] ADDR_CONFIG     = 5'h06;
  localparam logic [4:0] ADDR_DENOM      = 5'h07;
  localparam logic [4:0] ADDR_CH1        = 5'h08;
  localparam logic [4:0] ADDR_CH2        = 5'h09;
  localparam logic [4:0] ADDR_GAIN       = 5'h0A;
  localparam logic [4:0] ADDR_ONES       = 5'h1E;

  // Reset values
  localparam logic [7:0]  STATUS_RESET = 8'h40;
  localparam logic [15:0] CONFIG_RESET = 16'h000C;
  localparam logic [11:0] DENOM_RESET  = 12'h03F;
  localparam logic [7:0]  CH1_RESET    = 8'h80;
  localparam logic [5:0]  CH2_RESET    = 6'h00;
  localparam logic [7:0]  GAIN_RESET   = 8'h00;

  // Field positions
  localparam int CMD_WRITE_BIT = 7;
  localparam int WAVE_SRC_HI   = 14;
  localparam int WAVE_SRC_LO   = 13;
  localparam int INTEG_BIT     = 7;
  localparam logic [7:0] CH1_MASK = 8'hBF;

  // Transfer lengths in bits, always whole bytes, and index of the last command bit
  localparam logic [5:0] BITS_1B  = 6'h08;
  localparam logic [5:0] BITS_2B  = 6'h10;
  localparam logic [5:0] BITS_3B  = 6'h18;
  localparam logic [5:0] BITS_5B  = 6'h28;
  localparam logic [5:0] CMD_LAST = 6'h07;

  // Serial port phase
  typedef enum logic [1:0] {
    SRP_CMD = 2'b00,
    SRP_RD  = 2'b01,
    SRP_WR  = 2'b10
  } srp_mode_t;

  // Bits moved for one register access
  function automatic logic [5:0] srp_len_bits(input logic [4:0] addr,
                                              input logic       wave_long);
    case (addr)
      ADDR_WAVEFORM:                srp_len_bits = wave_long ? BITS_5B : BITS_3B;
      ADDR_ENERGY, ADDR_ENERGY_CLR: srp_len_bits = BITS_5B;
      ADDR_CONFIG, ADDR_DENOM:      srp_len_bits = BITS_2B;
      default:                      srp_len_bits = BITS_1B;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== hdl/srp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage level synchroniser into the system clock
module srp_sync (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [3:0] async_i,
  output logic      [3:0] sync_o
);
  typedef struct packed {
    logic [3:0] meta;   // First stage, read only by the second
    logic [3:0] safe;   // Second stage
  } srp_sync_t;

  srp_sync_t s_q;
  srp_sync_t s_d;

  // Shift one stage per clock
  always_comb
  begin
    s_d      = s_q;
    s_d.meta = async_i;
    s_d.safe = s_q.meta;
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sync_o = s_q.safe;
endmodule
`default_nettype wire

// ===== hdl/srp_toggle.sv
`timescale 1ns/1ps
`default_nettype none
// Flips once per rising chip select, so an abort is never missed
module srp_toggle (
  input  wire logic cs_b_i,
  input  wire logic rst_b_i,
  output logic      tgl_o
);
  typedef struct packed {
    logic tgl;   // Abort count parity
  } srp_tgl_t;

  srp_tgl_t t_q;
  srp_tgl_t t_d;

  // Invert on every deselect
  always_comb
  begin
    t_d     = t_q;
    t_d.tgl = ~t_q.tgl;
  end

  // Clocked by the chip select pin itself
  always_ff @(posedge cs_b_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      t_q <= '0;
    else
      t_q <= t_d;
  end

  assign tgl_o = t_q.tgl;
endmodule
`default_nettype wire

// ===== hdl/srp_top.sv
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// [R1] Data-out changes on rising serial clock
// [R2] Host sends read command, MSB zero
// [R3] Low five command bits address register
// [R4] Drive from next rising edge, MSB first
// [R5] After last bit float on falling edge
// [R6] Chip select high aborts, floats output
// [R7] Whole register copied before shifting out
// [R8] Host waits 4 us after writes
// [R9] Ones count cleared before first bit
// [R10] Each sent bit added to ones count
// [R11] Reading ones count recounts itself
// [R12] Waveform read-only, source and length selectable
// [R13] Read-only 40-bit active energy accumulator
// [R14] Clear-on-read energy view
// [R15] Interrupt status read-only, reset 40h
// [R16] Status view cleared after read
// [R17] 16-bit config, reset 000Ch, readable
// [R18] 12-bit pulse divider, reset 3Fh
// [R19] Integrator enable plus channel 1 offset
// [R20] 6-bit channel 2 offset
// [R21] 8-bit amplifier gain
// [R22] Host write command has MSB one
// [R23] Data-in sampled on falling serial clock
// [R24] Chip select fall restarts command mode
// [R25] Whole bytes, MSB first, right justified
// [R26] Padding bits read as zero
module srp_top (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_b_i,
  input  wire logic        din_i,
  output logic             dout_o,
  output logic             dout_oe_o,
  input  wire logic [23:0] power_sample_i,
  input  wire logic        power_valid_i,
  input  wire logic [39:0] waveform_i,
  input  wire logic [7:0]  status_event_i,
  output logic [15:0]      operating_config_o,
  output logic [1:0]       waveform_source_o,
  output logic [11:0]      pulse_divider_denominator_o,
  output logic             integrator_enable_o,
  output logic [5:0]       channel1_offset_o,
  output logic [5:0]       channel2_offset_o,
  output logic [7:0]       amplifier_gain_o
);
  import srp_pkg::*;

  // Falling-edge side: command and write data
  typedef struct packed {
    srp_mode_t   mode;
    logic [5:0]  cnt;        // Bit index inside the phase
    logic [6:0]  cmd_sh;     // Command bits seen so far
    logic [4:0]  addr;       // Held until next command ends
    logic [5:0]  nbits;      // Length of this access
    logic [15:0] wdata;      // Write bits, right justified
    logic        rd_go;      // Toggles when a read is armed
    logic        done_tgl;   // Toggles when a read completes
    logic        wr_tgl;     // Toggles when a write completes
    logic        busy;       // Transfer in progress
    logic        abort_seen; // Last abort parity handled
  } srp_neg_t;

  // Rising-edge side: read shifter and ones count
  typedef struct packed {
    logic [39:0] sh;
    logic [5:0]  left;
    logic [5:0]  ones;
    logic        dout;
    logic        seen;
    logic        abort_seen;
  } srp_pos_t;

  // System clock side: register file
  typedef struct packed {
    logic        done_prev;
    logic        wr_prev;
    logic [39:0] snap_wave;
    logic [39:0] snap_energy;
    logic [7:0]  snap_status;
    logic [39:0] energy;
    logic [7:0]  status;
    logic [15:0] cfg;
    logic [11:0] denom;
    logic [7:0]  ch1;
    logic [5:0]  ch2;
    logic [7:0]  gain;
  } srp_core_t;

  srp_neg_t  n_q;
  srp_neg_t  n_d;
  srp_pos_t  p_q;
  srp_pos_t  p_d;
  srp_core_t c_q;
  srp_core_t c_d;

  logic        abort_tgl;   // Parity of rising chip select edges
  logic [3:0]  sy;          // Synchronised link levels
  logic        fresh_n;     // Falling edge starts after an abort
  srp_mode_t   cur_mode;    // Phase seen by this falling edge
  logic [5:0]  cur_cnt;     // Count seen by this falling edge
  logic [7:0]  cmd_byte;    // Command as completed now
  logic        wave_long;   // Waveform read is five bytes
  logic [39:0] rd_val;      // Right-justified read value
  logic [39:0] aligned;     // Read value moved to the MSB
  logic        rd_load;     // First rising edge of a read
  logic        rd_shift;    // Later rising edges of a read
  logic        link_live;   // No abort pending on either edge
  logic        freeze;      // Snapshot held for the link
  logic        done_ev;     // Read finished, system side
  logic        wr_ev;       // Write finished, system side
  logic [39:0] energy_add;  // Sign-extended power sample

  srp_toggle u_abort (
    .cs_b_i  (cs_b_i),
    .rst_b_i (rst_b_i),
    .tgl_o   (abort_tgl)
  );

  // Levels and toggles only; addr and data are stable by then
  srp_sync u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i ({cs_b_i, n_q.busy, n_q.done_tgl, n_q.wr_tgl}),
    .sync_o  (sy)
  );

  // Quasi-static: config only changes between transfers
  assign wave_long = (c_q.cfg[WAVE_SRC_HI:WAVE_SRC_LO] == 2'b00);
  assign fresh_n   = (abort_tgl != n_q.abort_seen);
  assign cur_mode  = fresh_n ? SRP_CMD : n_q.mode;
  assign cur_cnt   = fresh_n ? 6'h00 : n_q.cnt;
  assign cmd_byte  = {n_q.cmd_sh, din_i};

  // Falling-edge next state
  always_comb
  begin
    n_d = n_q;
    // [R6] Ignore edges while deselected
    if (!cs_b_i)
    begin
      // [R24] First edge after deselect restarts command
      if (fresh_n)
      begin
        n_d.abort_seen = abort_tgl;
        n_d.mode       = SRP_CMD;
      end
      // [R23] Command and write branches sample data-in here
      case (cur_mode)
        SRP_CMD:
        begin
          n_d.busy   = 1'b1;
          n_d.cmd_sh = cmd_byte[6:0];
          n_d.cnt    = cur_cnt + 6'h01;
          if (cur_cnt == CMD_LAST)
          begin
            // [R3] Low five bits select the register
            n_d.addr  = cmd_byte[4:0];
            // [R25] Length in whole bytes
            n_d.nbits = srp_len_bits(cmd_byte[4:0], wave_long);
            n_d.cnt   = 6'h00;
            // [R22] MSB one means write
            if (cmd_byte[CMD_WRITE_BIT])
              n_d.mode = SRP_WR;
            // [R2] MSB zero means read
            else
            begin
              n_d.mode  = SRP_RD;
              n_d.rd_go = ~n_q.rd_go;
            end
          end
        end
        SRP_RD:
        begin
          n_d.cnt = cur_cnt + 6'h01;
          // [R5] Back to command mode on the last falling edge
          if (cur_cnt == n_q.nbits - 6'h01)
          begin
            n_d.mode     = SRP_CMD;
            n_d.cnt      = 6'h00;
            n_d.busy     = 1'b0;
            n_d.done_tgl = ~n_q.done_tgl;
          end
        end
        SRP_WR:
        begin
          n_d.cnt   = cur_cnt + 6'h01;
          n_d.wdata = {n_q.wdata[14:0], din_i};
          // Publish only a complete write
          if (cur_cnt == n_q.nbits - 6'h01)
          begin
            n_d.mode   = SRP_CMD;
            n_d.cnt    = 6'h00;
            n_d.busy   = 1'b0;
            n_d.wr_tgl = ~n_q.wr_tgl;
          end
        end
        default:
          n_d.mode = SRP_CMD;
      endcase
    end
  end

  // Falling-edge register
  always_ff @(negedge sclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      n_q <= '0;
    else
      n_q <= n_d;
  end

  // Read value by address
  always_comb
  begin
    rd_val = '0;
    // [R26] Unused upper bits stay zero
    case (n_q.addr)
      // [R12] Snapshot of the waveform sample
      ADDR_WAVEFORM:
        rd_val = wave_long ? c_q.snap_wave : {16'h0000, c_q.snap_wave[23:0]};
      // [R13] Energy accumulator
      ADDR_ENERGY:     rd_val = c_q.snap_energy;
      ADDR_ENERGY_CLR: rd_val = c_q.snap_energy;
      // [R15] Interrupt status
      ADDR_STATUS:     rd_val = {32'h0000_0000, c_q.snap_status};
      ADDR_STATUS_CLR: rd_val = {32'h0000_0000, c_q.snap_status};
      // [R17] Config readable at any time
      ADDR_CONFIG:     rd_val = {24'h00_0000, c_q.cfg};
      ADDR_DENOM:      rd_val = {28'h000_0000, c_q.denom};
      ADDR_CH1:        rd_val = {32'h0000_0000, c_q.ch1};
      ADDR_CH2:        rd_val = {34'h0, c_q.ch2};
      ADDR_GAIN:       rd_val = {32'h0000_0000, c_q.gain};
      // [R11] Count of the previous read goes out
      ADDR_ONES:       rd_val = {34'h0, p_q.ones};
      default:         rd_val = '0;
    endcase
  end

  // [R25] MSB of the first byte leads
  assign aligned   = rd_val << (BITS_5B - n_q.nbits);
  assign link_live = (abort_tgl == n_q.abort_seen) && (abort_tgl == p_q.abort_seen);
  assign rd_load   = !cs_b_i && (abort_tgl == p_q.abort_seen) && (n_q.mode == SRP_RD)
                     && (p_q.seen != n_q.rd_go);
  assign rd_shift  = !cs_b_i && (abort_tgl == p_q.abort_seen) && (n_q.mode == SRP_RD)
                     && (p_q.seen == n_q.rd_go) && (p_q.left != 6'h00);

  // Rising-edge next state
  always_comb
  begin
    p_d = p_q;
    // An abort cancels any armed read
    if (!cs_b_i && (abort_tgl != p_q.abort_seen))
    begin
      p_d.abort_seen = abort_tgl;
      p_d.seen       = n_q.rd_go;
    end
    // [R7] Whole register captured in one edge
    else if (rd_load)
    begin
      p_d.seen = n_q.rd_go;
      p_d.sh   = aligned;
      p_d.dout = aligned[39];
      p_d.left = n_q.nbits - 6'h01;
      // [R9] Count restarts with the first bit
      p_d.ones = {5'h00, aligned[39]};
    end
    // [R1] One bit per rising edge
    else if (rd_shift)
    begin
      p_d.sh   = {p_q.sh[38:0], 1'b0};
      p_d.dout = p_q.sh[38];
      p_d.left = p_q.left - 6'h01;
      // [R10] Add each presented bit
      p_d.ones = p_q.ones + {5'h00, p_q.sh[38]};
    end
  end

  // Rising-edge register
  always_ff @(posedge sclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      p_q <= '0;
    else
      p_q <= p_d;
  end

  // [R4] Driving starts with the first loaded bit
  // [R6] Chip select high floats at once
  assign dout_oe_o = link_live && !cs_b_i && (n_q.mode == SRP_RD)
                     && (p_q.seen == n_q.rd_go);
  assign dout_o    = p_q.dout;

  // System side events
  assign freeze     = sy[2] && !sy[3];
  assign done_ev    = (sy[1] != c_q.done_prev);
  assign wr_ev      = (sy[0] != c_q.wr_prev);
  assign energy_add = power_valid_i ? {{16{power_sample_i[23]}}, power_sample_i} : '0;

  // Register file next state
  always_comb
  begin
    c_d           = c_q;
    c_d.done_prev = sy[1];
    c_d.wr_prev   = sy[0];
    // [R14] Remove what was read, keep newer energy
    if (done_ev && (n_q.addr == ADDR_ENERGY_CLR))
      c_d.energy = c_q.energy - c_q.snap_energy + energy_add;
    // [R13] Integrate power
    else
      c_d.energy = c_q.energy + energy_add;
    // [R16] Clear reported flags; new events win
    if (done_ev && (n_q.addr == ADDR_STATUS_CLR))
      c_d.status = (c_q.status & ~c_q.snap_status) | status_event_i;
    else
      c_d.status = c_q.status | status_event_i;
    // [R7] Hold the copy while the link may read it
    if (!freeze)
    begin
      c_d.snap_wave   = waveform_i;
      c_d.snap_energy = c_q.energy;
      c_d.snap_status = c_q.status;
    end
    // Commit a finished write
    if (wr_ev)
    begin
      case (n_q.addr)
        // [R17] Operating config
        ADDR_CONFIG: c_d.cfg   = n_q.wdata;
        // [R18] Pulse divider denominator
        ADDR_DENOM:  c_d.denom = n_q.wdata[11:0];
        // [R19] Bit 6 is not stored
        ADDR_CH1:    c_d.ch1   = n_q.wdata[7:0] & CH1_MASK;
        // [R20] Channel 2 offset
        ADDR_CH2:    c_d.ch2   = n_q.wdata[5:0];
        // [R21] Amplifier gain
        ADDR_GAIN:   c_d.gain  = n_q.wdata[7:0];
        default:     c_d.cfg   = c_q.cfg;
      endcase
    end
  end

  // Register file
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      c_q        <= '0;
      // [R15] Status starts at its reset value
      c_q.status <= STATUS_RESET;
      c_q.cfg    <= CONFIG_RESET;
      c_q.denom  <= DENOM_RESET;
      c_q.ch1    <= CH1_RESET;
      c_q.ch2    <= CH2_RESET;
      c_q.gain   <= GAIN_RESET;
    end
    else
      c_q <= c_d;
  end

  assign operating_config_o          = c_q.cfg;
  assign waveform_source_o           = c_q.cfg[WAVE_SRC_HI:WAVE_SRC_LO];
  assign pulse_divider_denominator_o = c_q.denom;
  assign integrator_enable_o         = c_q.ch1[INTEG_BIT];
  assign channel1_offset_o           = c_q.ch1[5:0];
  assign channel2_offset_o           = c_q.ch2;
  assign amplifier_gain_o            = c_q.gain;

  // Read steps on the serial clock
  sequence s_rd_load;
    rd_load;
  endsequence

  sequence s_rd_shift;
    rd_shift;
  endsequence

  property p_ones_cleared;
    @(posedge sclk_i) disable iff (!rst_b_i)
    s_rd_load |=> (p_q.ones == {5'h00, p_q.dout});
  endproperty

  property p_msb_first;
    @(posedge sclk_i) disable iff (!rst_b_i)
    s_rd_load |=> (dout_o == $past(aligned[39])) && dout_oe_o;
  endproperty

  property p_ones_add;
    @(posedge sclk_i) disable iff (!rst_b_i)
    s_rd_shift |=> (p_q.ones == $past(p_q.ones) + {5'h00, dout_o});
  endproperty

  property p_read_end;
    @(negedge sclk_i) disable iff (!rst_b_i)
    (!cs_b_i && !fresh_n && n_q.mode == SRP_RD && n_q.cnt == n_q.nbits - 6'h01)
      |=> (n_q.mode == SRP_CMD) && !dout_oe_o;
  endproperty

  property p_cmd_addr;
    @(negedge sclk_i) disable iff (!rst_b_i)
    (!cs_b_i && cur_mode == SRP_CMD && cur_cnt == CMD_LAST)
      |=> (n_q.addr == $past(cmd_byte[4:0]));
  endproperty

  a_ones_cleared: assert property (p_ones_cleared) // [R9]
    else $error("ones count not restarted at first bit");
  a_msb_first: assert property (p_msb_first) // [R4]
    else $error("first read bit not the register MSB");
  a_ones_add: assert property (p_ones_add) // [R10]
    else $error("ones count missed a sent bit");
  a_read_end: assert property (p_read_end) // [R5]
    else $error("port did not float after last bit");
  a_cmd_addr: assert property (p_cmd_addr) // [R3]
    else $error("command address not taken");
  a_oe_cs_high: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R6]
    cs_b_i |-> !dout_oe_o)
    else $error("data-out driven while deselected");
  a_snap_frozen: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R7]
    (freeze && $past(freeze)) |-> $stable(c_q.snap_energy))
    else $error("snapshot moved during a transfer");
  a_energy_cleared: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R14]
    (done_ev && n_q.addr == ADDR_ENERGY_CLR && !power_valid_i)
      |=> (c_q.energy == $past(c_q.energy) - $past(c_q.snap_energy)))
    else $error("energy not cleared after read");
  a_status_cleared: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R16]
    (done_ev && n_q.addr == ADDR_STATUS_CLR && status_event_i == 8'h00)
      |=> ((c_q.status & $past(c_q.snap_status)) == 8'h00))
    else $error("status flags not cleared after read");
  a_config_write: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R17]
    (wr_ev && n_q.addr == ADDR_CONFIG) |=> (c_q.cfg == $past(n_q.wdata)))
    else $error("config write not committed");
endmodule
`default_nettype wire

// ===== bench/srp_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host model; serial clock idles high and runs only inside frames
module srp_host (
  output logic      sclk_o,
  output logic      cs_b_o,
  output logic      din_o,
  input  wire logic dout_i,
  input  wire logic dout_oe_i
);
  // Line as seen by the host, floating when released
  wire logic dout_w;
  assign dout_w = dout_oe_i ? dout_i : 1'bz;

  // Idle levels
  initial
  begin
    sclk_o = 1'b1;
    cs_b_o = 1'b1;
    din_o  = 1'b0;
  end

  // One frame; stops after stop data bits, aborting if short of nb
  task automatic xfer(input logic [7:0] cmd, input logic [39:0] wd, input int nb,
                      input int stop, output logic [39:0] rd, output logic oe);
    int i;
    rd = 40'h0;
    oe = 1'b1;
    cs_b_o = 1'b0;
    // Odd lead keeps link edges off the system clock grid
    #103.3;
    for (i = 0; i < 8 + stop; i++)
    begin
      din_o = (i < 8) ? cmd[7 - i] : wd[nb + 7 - i];
      #80;
      // Sample just before the falling edge
      if (i >= 8)
        rd = {rd[38:0], dout_w};
      sclk_o = 1'b0;
      #1;
      oe = dout_oe_i;
      #79;
      sclk_o = 1'b1;
    end
    if (stop < nb)
    begin
      cs_b_o = 1'b1;
      #1;
      oe = dout_oe_i;
    end
    #100;
    cs_b_o = 1'b1;
    // Released data line must not keep its last value
    din_o = ~din_o;
    #300;
    if (cmd[7])
      #4000;
  endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the serial read port
module testbench;
  import srp_pkg::*;
  logic        clk_i;
  logic        rst_b_i;
  logic        sclk;
  logic        cs_b;
  logic        din;
  logic        dout;
  logic        dout_oe;
  logic [23:0] power_sample_i;
  logic        power_valid_i;
  logic [39:0] waveform_i;
  logic [7:0]  status_event_i;
  logic [15:0] cfg;
  logic [1:0]  wsrc;
  logic [11:0] denom;
  logic        integ;
  logic [5:0]  ch1;
  logic [5:0]  ch2;
  logic [7:0]  gain;
  logic [39:0] rv;
  logic        oe;
  int          n_errors = 0;
  int          checked = 0;

  // Device under test
  srp_top uut (
    .clk_i                       (clk_i),
    .rst_b_i                     (rst_b_i),
    .sclk_i                      (sclk),
    .cs_b_i                      (cs_b),
    .din_i                       (din),
    .dout_o                      (dout),
    .dout_oe_o                   (dout_oe),
    .power_sample_i              (power_sample_i),
    .power_valid_i               (power_valid_i),
    .waveform_i                  (waveform_i),
    .status_event_i              (status_event_i),
    .operating_config_o          (cfg),
    .waveform_source_o           (wsrc),
    .pulse_divider_denominator_o (denom),
    .integrator_enable_o         (integ),
    .channel1_offset_o           (ch1),
    .channel2_offset_o           (ch2),
    .amplifier_gain_o            (gain)
  );

  // Host on the far side of the link
  srp_host host (
    .sclk_o    (sclk),
    .cs_b_o    (cs_b),
    .din_o     (din),
    .dout_i    (dout),
    .dout_oe_i (dout_oe)
  );

  // System clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Value compare
  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Full read, judged on data and on release after the last bit
  task automatic rd(input logic [4:0] a, input int nb, input string what,
                    input logic [39:0] exp);
    host.xfer({3'b000, a}, 40'h0, nb, nb, rv, oe);
    check(what, exp, rv);
    check({what, " release"}, 40'h0, {39'h0, oe});
  endtask

  // Full write
  task automatic wr(input logic [4:0] a, input logic [39:0] d, input int nb);
    host.xfer({3'b100, a}, d, nb, nb, rv, oe);
  endtask

  // Closing report
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Values after reset
  task automatic test_reset();
    rd(ADDR_STATUS, 8, "status", {32'h0, STATUS_RESET});
    rd(ADDR_CONFIG, 16, "config", {24'h0, CONFIG_RESET});
    rd(ADDR_DENOM, 16, "denom", {28'h0, DENOM_RESET});
    rd(ADDR_GAIN, 8, "gain", 40'h0);
    rd(ADDR_CH2, 8, "ch2", 40'h0);
    rd(ADDR_ENERGY, 40, "energy", 40'h0);
    rd(ADDR_WAVEFORM, 40, "wave40", waveform_i);
    rd(ADDR_CH1, 8, "ch1", {32'h0, CH1_RESET});
    rd(ADDR_ONES, 8, "ones", 40'h1);
    check("cfg port", 40'hC, {24'h0, cfg});
    $display("test reset done");
  endtask

  // Writes, pad handling, unmapped place, snapshot
  task automatic test_writes();
    wr(ADDR_CONFIG, 40'h2005, 16);
    wr(ADDR_DENOM, 40'hFABC, 16);
    wr(ADDR_CH1, 40'h7F, 8);
    wr(ADDR_CH2, 40'hFF, 8);
    wr(ADDR_GAIN, 40'hA5, 8);
    wr(5'h0B, 40'h77, 8);
    rd(ADDR_CONFIG, 16, "config", 40'h2005);
    rd(ADDR_DENOM, 16, "denom", 40'hABC);
    rd(ADDR_CH1, 8, "ch1", 40'h3F);
    rd(ADDR_CH2, 8, "ch2", 40'h3F);
    rd(5'h0B, 8, "unmapped", 40'h0);
    check("src port", 40'h1, {38'h0, wsrc});
    check("denom port", 40'hABC, {28'h0, denom});
    check("integ port", 40'h0, {39'h0, integ});
    check("ch1 port", 40'h3F, {34'h0, ch1});
    check("ch2 port", 40'h3F, {34'h0, ch2});
    check("gain port", 40'hA5, {32'h0, gain});
    // Source changes in mid transfer; the copy taken at command must go out
    fork
      rd(ADDR_WAVEFORM, 24, "wave24", 40'h56_789A);
      begin
        #3000;
        @(posedge clk_i);
        waveform_i <= 40'h0;
      end
    join
    $display("test writes done");
  endtask

  // Energy accumulation and clear on read
  task automatic test_energy();
    repeat (10)
    begin
      @(posedge clk_i);
      power_sample_i <= 24'h64;
      power_valid_i  <= 1'b1;
    end
    @(posedge clk_i);
    power_valid_i <= 1'b0;
    rd(ADDR_ENERGY, 40, "energy", 40'h3E8);
    rd(ADDR_ENERGY_CLR, 40, "energy clr", 40'h3E8);
    rd(ADDR_ENERGY, 40, "energy after", 40'h0);
    $display("test energy done");
  endtask

  // Status flags and clear on read
  task automatic test_status();
    @(posedge clk_i);
    status_event_i <= 8'h05;
    @(posedge clk_i);
    status_event_i <= 8'h00;
    rd(ADDR_STATUS, 8, "status", 40'h45);
    rd(ADDR_STATUS_CLR, 8, "status clr", 40'h45);
    rd(ADDR_STATUS, 8, "status after", 40'h0);
    $display("test status done");
  endtask

  // Aborted read and write, then ones count over itself
  task automatic test_abort_ones();
    host.xfer({3'b000, ADDR_GAIN}, 40'h0, 8, 4, rv, oe);
    check("abort release", 40'h0, {39'h0, oe});
    check("abort bits", 40'hA, rv);
    host.xfer({3'b100, ADDR_CH2}, 40'h0, 8, 4, rv, oe);
    rd(ADDR_CH2, 8, "ch2 kept", 40'h3F);
    rd(ADDR_GAIN, 8, "gain", 40'hA5);
    rd(ADDR_ONES, 8, "ones", 40'h4);
    rd(ADDR_ONES, 8, "ones self", 40'h1);
    $display("test abort and ones done");
  endtask

  // Hang guard
  initial
  begin
    #2000000;
    n_errors++;
    $display("unexpected timeout: expected end, seen hang");
    print_verdict();
  end

  // Main sequence
  initial
  begin
    rst_b_i        = 1'b0;
    power_sample_i = 24'h0;
    power_valid_i  = 1'b0;
    waveform_i     = 40'h12_3456_789A;
    status_event_i = 8'h00;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    test_reset();
    test_writes();
    test_energy();
    test_status();
    test_abort_ones();
    print_verdict();
  end
endmodule
`default_nettype wire
